//--- rtl/adc_result_seq.sv
`timescale 1ns/1ps
module adc_result_seq
  import adc_seq_pkg::*;
#(
  parameter bit HAS_DMA = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  // Converter core
  input wire logic [11:0] conv_data_i,
  input wire logic [4:0] channel_i,
  output logic [4:0] conv_input_o,
  // Pins
  input wire logic [15:0] pin_in_i,
  output logic [15:0] pin_digital_o,
  output logic [15:0] pin_in_buf_en_o,
  // Interrupt
  output logic irq_o
);

  // ****************************************
  // Registers
  // ****************************************
  reg_req_t req;
  logic [15:0] ctrl_one_q;
  logic [15:0] ctrl_two_q;
  logic [31:0] scan_q;
  logic [15:0] cfg_a_q;
  logic [15:0] cfg_b_q;
  logic [1:0] stat_q;
  logic [1:0] mask_q;
  logic [11:0] slots_q [NUM_SLOTS];
  logic [3:0] wptr_q;
  logic [3:0] spi_cnt_q;
  logic [4:0] scan_pos_q;
  logic done_q;
  logic unread_q;
  logic [15:0] rdata_q;
  logic [15:0] pin_s1_q;
  logic [15:0] pin_s2_q;
  logic [15:0] pin_dig_q;
  logic [15:0] buf_en_q;
  logic irq_q;
  conv_state_t state_q;
  logic [3:0] tick_q;
  logic [4:0] in_q;
  conv_done_t fin;
  logic point;
  logic conv_start;
  logic [4:0] pick_next;
  logic pick_found;
  logic [4:0] wrap_next;
  logic wrap_found;
  logic wr_stat;
  logic [15:0] result_rd;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  function automatic logic hit(input reg_req_t r, input logic [3:0] off);
    hit = r.addr == off;
  endfunction : hit

  // ****************************************
  // Control registers
  // ****************************************
  assign wr_stat = req.wr && hit(req, OFF_IRQ_STAT);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_two_q <= RST_CTRL;
      scan_q <= RST_SCAN;
      cfg_a_q <= RST_PIN_CFG;
      cfg_b_q <= RST_PIN_CFG;
      mask_q <= 2'h0;
    end else if (req.wr) begin
      if (hit(req, OFF_CTRL_TWO)) ctrl_two_q <= req.wdata;
      if (hit(req, OFF_SCAN_LO)) scan_q[15:0] <= req.wdata;
      if (hit(req, OFF_SCAN_HI)) scan_q[31:16] <= req.wdata;
      if (hit(req, OFF_PIN_CFG_A)) cfg_a_q <= req.wdata;
      if (hit(req, OFF_PIN_CFG_B)) cfg_b_q <= req.wdata;
      if (hit(req, OFF_IRQ_MASK)) mask_q <= req.wdata[1:0];
    end
  end

  // Sample bit self-clears when the conversion starts.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ctrl_one_q <= RST_CTRL;
    end else if (req.wr && hit(req, OFF_CTRL_ONE)) begin
      ctrl_one_q <= req.wdata;
    end else if (conv_start) begin
      ctrl_one_q[CTRL1_SAMPLE_BIT] <= 1'b0;
    end
  end

  // ****************************************
  // Conversion sequencer
  // ****************************************
  assign conv_start = (state_q == ST_SAMPLE) && ctrl_one_q[CTRL1_ON_BIT];
  assign fin = '{valid: (state_q == ST_CONVERT) && (tick_q == 4'(CONV_CYCLES - 1)),
    input_num: in_q, slot: wptr_q};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      tick_q <= 4'h0;
      in_q <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (ctrl_one_q[CTRL1_SAMPLE_BIT] && ctrl_one_q[CTRL1_ON_BIT]) state_q <= ST_SAMPLE;
        end
        ST_SAMPLE: begin
          if (conv_start) begin
            state_q <= ST_CONVERT;
            tick_q <= 4'h0;
            in_q <= ctrl_two_q[CTRL2_SCAN_BIT] ? scan_pos_q : channel_i;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_CONVERT: begin
          tick_q <= tick_q + 4'h1;
          if (fin.valid) state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Done flag
  // ****************************************
  // Software may clear done; a completion in the same cycle wins.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (fin.valid) begin
      done_q <= 1'b1;
    end else if (conv_start) begin
      done_q <= 1'b0;
    end else if (req.wr && hit(req, OFF_CTRL_ONE) && !req.wdata[CTRL1_DONE_BIT]) begin
      done_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt point counting
  // ****************************************
  assign point = fin.valid && (spi_cnt_q == ctrl_two_q[CTRL2_SPI_MSB:CTRL2_SPI_LSB]);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      spi_cnt_q <= 4'h0;
    end else if (point || (req.wr && hit(req, OFF_CTRL_TWO))) begin
      spi_cnt_q <= 4'h0;
    end else if (fin.valid) begin
      spi_cnt_q <= spi_cnt_q + 4'h1;
    end
  end

  // ****************************************
  // Scan list position
  // ****************************************
  adc_scan_pick u_pick_next (
    .scan_sel_i(scan_q),
    .start_i(5'(in_q + 5'h01)),
    .next_o(pick_next),
    .found_o(pick_found)
  );

  adc_scan_pick u_pick_first (
    .scan_sel_i(scan_q),
    .start_i(5'h00),
    .next_o(wrap_next),
    .found_o(wrap_found)
  );

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      scan_pos_q <= 5'h00;
    end else if (req.wr && (hit(req, OFF_SCAN_LO) || hit(req, OFF_SCAN_HI))) begin
      scan_pos_q <= 5'h00;
    end else if (point || (fin.valid && (in_q == 5'h1f || !pick_found))) begin
      scan_pos_q <= wrap_found ? wrap_next : 5'h00;
    end else if (fin.valid) begin
      scan_pos_q <= pick_next;
    end else if (wrap_found && !scan_q[scan_pos_q]) begin
      scan_pos_q <= wrap_next;
    end
  end

  assign conv_input_o = in_q;

  // ****************************************
  // Result storage
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wptr_q <= 4'h0;
    end else if (HAS_DMA || point) begin
      wptr_q <= 4'h0;
    end else if (fin.valid) begin
      wptr_q <= wptr_q + 4'h1;
    end
  end

  // Slot is fixed by the sequence pointer alone, never by input number.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SLOTS; i++) slots_q[i] <= 12'h000;
    end else if (fin.valid) begin
      slots_q[fin.slot] <= conv_data_i;
    end
  end

  // With HAS_DMA set, a result overwritten before being read is flagged as overrun.
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      unread_q <= 1'b0;
    end else if (fin.valid) begin
      unread_q <= 1'b1;
    end else if (req.rd && req.addr == OFF_RESULT) begin
      unread_q <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      stat_q <= 2'h0;
    end else begin
      stat_q[IRQ_POINT_BIT] <= point
        || (stat_q[IRQ_POINT_BIT] && !(wr_stat && req.wdata[IRQ_POINT_BIT]));
      stat_q[IRQ_OVERRUN_BIT] <= (HAS_DMA && fin.valid && unread_q)
        || (stat_q[IRQ_OVERRUN_BIT] && !(wr_stat && req.wdata[IRQ_OVERRUN_BIT]));
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign irq_o = irq_q;

  // ****************************************
  // Pin configuration
  // ****************************************
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      pin_s1_q <= 16'h0000;
      pin_s2_q <= 16'h0000;
    end else begin
      pin_s1_q <= pin_in_i;
      pin_s2_q <= pin_s1_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      buf_en_q <= 16'h0000;
      pin_dig_q <= 16'h0000;
    end else begin
      buf_en_q <= cfg_a_q & cfg_b_q;
      pin_dig_q <= pin_s2_q & cfg_a_q & cfg_b_q;
    end
  end

  assign pin_in_buf_en_o = buf_en_q;
  assign pin_digital_o = pin_dig_q;

  // ****************************************
  // Read data
  // ****************************************
  assign result_rd = {4'h0, slots_q[req.addr == OFF_RESULT ? 4'h0 : 4'h0]};

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        OFF_CTRL_ONE: rdata_q <= {ctrl_one_q[15:1], done_q};
        OFF_CTRL_TWO: rdata_q <= ctrl_two_q;
        OFF_SCAN_LO: rdata_q <= scan_q[15:0];
        OFF_SCAN_HI: rdata_q <= scan_q[31:16];
        OFF_PIN_CFG_A: rdata_q <= cfg_a_q;
        OFF_PIN_CFG_B: rdata_q <= cfg_b_q;
        OFF_IRQ_STAT: rdata_q <= {14'h0000, stat_q};
        OFF_IRQ_MASK: rdata_q <= {14'h0000, mask_q};
        OFF_RESULT: rdata_q <= result_rd;
        OFF_STATUS: rdata_q <= {11'h000, wptr_q, unread_q};
        default: rdata_q <= {4'h0, slots_q[req.addr - 4'ha]};
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ****************************************
  // Checks
  // ****************************************
  done_set_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fin.valid |=> done_q) else $error("done not set after completion");
  done_clr_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    conv_start |=> !done_q) else $error("done not cleared at start");
  done_hold_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    done_q && !conv_start && !req.wr |=> done_q) else $error("done dropped");
  irq_point_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    point |=> stat_q[IRQ_POINT_BIT]) else $error("point flag missing");
  irq_out_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    point && mask_q[IRQ_POINT_BIT] && !req.wr |=> ##1 irq_o) else $error("no irq");
  spi_wrap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    point |=> spi_cnt_q == 4'h0) else $error("count not restarted");
  slot_reset_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    point |=> wptr_q == 4'h0) else $error("pointer not reset");
  slot_step_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    !HAS_DMA && fin.valid && !point |=> wptr_q == $past(wptr_q) + 4'h1)
    else $error("pointer not stepped");
  slot_store_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    fin.valid |=> slots_q[$past(wptr_q)] == $past(conv_data_i)) else $error("bad slot");
  dma_single_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    HAS_DMA |-> wptr_q == 4'h0) else $error("dma pointer moved");
  scan_restart_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    point && wrap_found && !req.wr |=> scan_pos_q == $past(wrap_next))
    else $error("scan not restarted");
  pin_digital_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    ##1 buf_en_q == $past(cfg_a_q & cfg_b_q)) else $error("pin enable wrong");
  pin_zero_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
    (pin_digital_o & ~pin_in_buf_en_o) == 16'h0000) else $error("analog pin read");

  conv_cov_c: cover property (@(posedge clk_sys_i) fin.valid);
  point_cov_c: cover property (@(posedge clk_sys_i) point);
  scan_cov_c: cover property (@(posedge clk_sys_i) point && ctrl_two_q[CTRL2_SCAN_BIT]);
  irq_cov_c: cover property (@(posedge clk_sys_i) irq_o);

endmodule : adc_result_seq

//--- pkg/adc_seq_pkg.sv
package adc_seq_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] OFF_CTRL_ONE = 4'h0;
  localparam logic [3:0] OFF_CTRL_TWO = 4'h1;
  localparam logic [3:0] OFF_SCAN_LO = 4'h2;
  localparam logic [3:0] OFF_SCAN_HI = 4'h3;
  localparam logic [3:0] OFF_PIN_CFG_A = 4'h4;
  localparam logic [3:0] OFF_PIN_CFG_B = 4'h5;
  localparam logic [3:0] OFF_IRQ_STAT = 4'h6;
  localparam logic [3:0] OFF_IRQ_MASK = 4'h7;
  localparam logic [3:0] OFF_RESULT = 4'h8;
  localparam logic [3:0] OFF_STATUS = 4'h9;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL1_DONE_BIT = 0;
  localparam int CTRL1_SAMPLE_BIT = 1;
  localparam int CTRL1_ON_BIT = 15;
  localparam int CTRL2_SPI_LSB = 2;
  localparam int CTRL2_SPI_MSB = 5;
  localparam int CTRL2_SCAN_BIT = 10;
  localparam int IRQ_POINT_BIT = 0;
  localparam int IRQ_OVERRUN_BIT = 1;

  // ****************************************
  // Sizes and reset values
  // ****************************************
  localparam int NUM_SLOTS = 16;
  localparam int NUM_INPUTS = 32;
  localparam int CONV_CYCLES = 12;
  localparam logic [15:0] RST_CTRL = 16'h0000;
  localparam logic [15:0] RST_PIN_CFG = 16'h0000;
  localparam logic [31:0] RST_SCAN = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11
  } conv_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [4:0] input_num;
    logic [3:0] slot;
  } conv_done_t;

endpackage : adc_seq_pkg

//--- rtl/adc_scan_pick.sv
`timescale 1ns/1ps
module adc_scan_pick
  import adc_seq_pkg::*;
(
  // Scan list
  input wire logic [31:0] scan_sel_i,
  input wire logic [4:0] start_i,
  // Next entry
  output logic [4:0] next_o,
  output logic found_o
);

  // ****************************************
  // Finds the first selected input at or after start_i, no wrap.
  // ****************************************
  always_comb begin
    next_o = 5'h00;
    found_o = 1'b0;
    for (int i = NUM_INPUTS - 1; i >= 0; i--) begin
      if (scan_sel_i[i] && (5'(i) >= start_i)) begin
        next_o = 5'(i);
        found_o = 1'b1;
      end
    end
  end

endmodule : adc_scan_pick

//--- testbench/result_reader.sv
`timescale 1ns/1ps
module result_reader
  import adc_seq_pkg::*;
(
  // Clock
  input wire logic clk_sys_i,
  // Read data of both variants
  input wire logic [15:0] rdata_i,
  input wire logic [15:0] rdata_dma_i,
  // Register requests
  output reg_req_t req_o
);
  // ****************************************
  // Bus cycles
  // ****************************************
  initial begin
    req_o = '0;
  end

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    req_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    req_o.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [15:0] d, output logic [15:0] d_dma);
    @(posedge clk_sys_i);
    req_o <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    req_o.rd <= 1'b0;
    @(negedge clk_sys_i);
    d = rdata_i;
    d_dma = rdata_dma_i;
  endtask : rd

  // Clearing done first keeps a stale completion from passing for a fresh one.
  task automatic run_conv(output int polls, output logic [15:0] res_dma);
    logic [15:0] d;
    logic [15:0] dd;
    wr(OFF_CTRL_ONE, 16'h8000);
    wr(OFF_CTRL_ONE, 16'h8002);
    polls = 0;
    d = 16'h0000;
    while (d[CTRL1_DONE_BIT] !== 1'b1 && polls < 60) begin
      rd(OFF_CTRL_ONE, d, dd);
      polls++;
    end
    rd(OFF_RESULT, d, res_dma);
  endtask : run_conv
endmodule : result_reader

//--- testbench/adc_result_sequencing_tb.sv
`timescale 1ns/1ps
module adc_result_sequencing_tb
  import adc_seq_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  reg_req_t req;
  logic [15:0] rdata, rdata_dma, pin_in, dig, dig_d, buf_en, buf_en_d;
  logic [11:0] conv_data = 12'h000;
  logic [4:0] channel = 5'h00;
  logic [4:0] conv_in, conv_in_d;
  logic irq, irq_d;
  int failures = 0;
  int checks_done = 0;
  integer seed = 32'h9c3f_fbbf;

  always #50 clk_sys_i = ~clk_sys_i;

  adc_result_seq #(.HAS_DMA(1'b0)) dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(req.addr), .reg_wdata_i(req.wdata), .reg_wr_i(req.wr), .reg_rd_i(req.rd),
    .reg_rdata_o(rdata), .conv_data_i(conv_data), .channel_i(channel),
    .conv_input_o(conv_in), .pin_in_i(pin_in), .pin_digital_o(dig),
    .pin_in_buf_en_o(buf_en), .irq_o(irq));
  adc_result_seq #(.HAS_DMA(1'b1)) dut_dma (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .reg_addr_i(req.addr), .reg_wdata_i(req.wdata), .reg_wr_i(req.wr), .reg_rd_i(req.rd),
    .reg_rdata_o(rdata_dma), .conv_data_i(conv_data), .channel_i(channel),
    .conv_input_o(conv_in_d), .pin_in_i(pin_in), .pin_digital_o(dig_d),
    .pin_in_buf_en_o(buf_en_d), .irq_o(irq_d));
  result_reader rdr (.clk_sys_i(clk_sys_i), .rdata_i(rdata), .rdata_dma_i(rdata_dma),
    .req_o(req));

  // ****************************************
  // Checking and closing
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic logic [15:0] ext12(input logic [11:0] v);
    return {4'h0, v};
  endfunction : ext12

  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    #2_000_000;
    failures++;
    finish_test();
  end

  initial begin
    logic [15:0] d, dd, a, b;
    logic [11:0] res[$];
    logic [4:0] scan_exp[4];
    int n;
    pin_in = 16'h0000;
    scan_exp = '{5'h0f, 5'h10, 5'h0f, 5'h10};
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdr.rd(OFF_STATUS, d, dd);
    check("status", d, 16'h0000);
    check("irq", {15'h0, irq}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 16'hffff : 16'($random(seed));
      b = (i < 2) ? 16'hffff : 16'($random(seed));
      rdr.wr(OFF_PIN_CFG_A, a);
      rdr.wr(OFF_PIN_CFG_B, b);
      @(posedge clk_sys_i) pin_in <= 16'($random(seed));
      repeat (4) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      check("buf_en", buf_en, a & b);
      check("digital", dig, pin_in & a & b);
      check("buf_en_dma", buf_en_d, a & b);
      check("digital_dma", dig_d, pin_in & a & b);
    end
    // ****************************************
    // Five conversions, interrupt point at four
    // ****************************************
    rdr.wr(OFF_CTRL_TWO, 16'h000c);
    for (int k = 0; k < 5; k++) begin
      @(posedge clk_sys_i);
      conv_data <= 12'($random(seed));
      channel <= 5'($random(seed));
      rdr.run_conv(n, dd);
      check("done", {15'h0, n > 1 && n < 60}, 16'h0001);
      check("input", {11'h0, conv_in}, {11'h0, channel});
      check("input_dma", {11'h0, conv_in_d}, {11'h0, channel});
      check("dma_buffer", dd, ext12(conv_data));
      res.push_back(conv_data);
      rdr.rd(OFF_IRQ_STAT, d, dd);
      check("point", d & 16'h0001, {15'h0, k >= 3});
      check("irq_masked", {15'h0, irq}, 16'h0000);
      check("irq_masked_dma", {15'h0, irq_d}, 16'h0000);
    end
    repeat (10) @(posedge clk_sys_i);
    rdr.rd(OFF_CTRL_ONE, d, dd);
    check("done_held", d & 16'h0001, 16'h0001);
    for (int s = 1; s < 4; s++) begin
      rdr.rd(4'(s) + 4'ha, d, dd);
      check("slot", d, ext12(res[s]));
    end
    rdr.rd(OFF_RESULT, d, dd);
    check("slot0_wrap", d, ext12(res[4]));
    rdr.rd(OFF_STATUS, d, dd);
    check("wptr", d & 16'h001e, 16'h0002);
    rdr.wr(OFF_IRQ_MASK, 16'h0001);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("irq_on", {15'h0, irq}, 16'h0001);
    check("irq_on_dma", {15'h0, irq_d}, 16'h0001);
    rdr.wr(OFF_IRQ_STAT, 16'h0001);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    check("irq_off", {15'h0, irq}, 16'h0000);
    check("irq_off_dma", {15'h0, irq_d}, 16'h0000);
    // ****************************************
    // Scan list restarts at the interrupt point
    // ****************************************
    rdr.wr(OFF_SCAN_LO, 16'h8000);
    rdr.wr(OFF_SCAN_HI, 16'h0003);
    rdr.wr(OFF_CTRL_TWO, 16'h0404);
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_sys_i);
      channel <= 5'($random(seed));
      rdr.run_conv(n, dd);
      check("scan_input", {11'h0, conv_in}, {11'h0, scan_exp[k]});
    end
    // Two results with no read between them overrun the single buffer.
    for (int k = 0; k < 2; k++) begin
      rdr.wr(OFF_CTRL_ONE, 16'h8002);
      repeat (20) @(posedge clk_sys_i);
    end
    rdr.rd(OFF_IRQ_STAT, d, dd);
    check("overrun", d & 16'h0002, 16'h0000);
    check("overrun_dma", dd & 16'h0002, 16'h0002);
    finish_test();
  end
endmodule : adc_result_sequencing_tb
